// [cms_sync.sv]
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes the pins are static or slow against i_core_clk; no reset, data path only.
`timescale 1ns/1ps
`default_nettype none

module cms_sync #(
    parameter int W = 1
) (
    // Clock
    input  wire logic         i_core_clk,
    // Asynchronous levels
    input  wire logic [W-1:0] i_async,
    // Synchronised levels
    output logic      [W-1:0] o_sync
);

    //--------------------------------------------------------------------
    // Per-bit double flop
    //--------------------------------------------------------------------
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    for (genvar b = 0; b < W; b++) begin : g_bit
        always_ff @(posedge i_core_clk) begin
            meta_q[b] <= i_async[b];
            sync_q[b] <= meta_q[b];
        end
    end

    assign o_sync = sync_q;

endmodule // cms_sync

`default_nettype wire

// [cms_clock_mode_select.sv]
// Package and top of the CPU clock mode selector: strap capture, clock path selection,
// half-period edge generation and the multiplier-loop control outputs.
// Assumes the oscillator input and strap pins are asynchronous pins and i_srst is
// held for at least three i_core_clk edges so the strap pins settle through the synchroniser.
//
// Operation
// - Strap pins sampled while reset is asserted
// - Strap decode gives the eight multiplier factors
// - Pattern 001 selects divide-by-two prescaler
// - Prescaler phase lasts one input period
// - Pattern 011 selects direct drive, loop bypassed
// - Direct drive phases follow input duty cycle
// - Two direct phases equal one input period
// - Watchdog enabled: loop free-runs in bypass modes
// - Watchdog disabled: loop off in bypass modes
// - Both CPU clock edges trigger actions
// - Half-period unit counts CPU clock edges
// - Other patterns use multiplier loop output
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

package cms_pkg;

    //--------------------------------------------------------------------
    // Register map
    //--------------------------------------------------------------------
    localparam int              CMS_ADDR_W      = 8;
    localparam int              CMS_DATA_W      = 32;
    localparam logic [7:0]      CMS_OFS_SYSCFG  = 8'h00;
    localparam logic [7:0]      CMS_OFS_STATUS  = 8'h04;
    localparam int              CMS_OWD_DIS_BIT = 4;
    localparam logic            CMS_OWD_DIS_RST = 1'b0;

    //--------------------------------------------------------------------
    // Strap patterns and factors
    //--------------------------------------------------------------------
    localparam logic [2:0]      CMS_STRAP_DFLT   = 3'h7;
    localparam logic [2:0]      CMS_STRAP_PRESC  = 3'h1;
    localparam logic [2:0]      CMS_STRAP_DIRECT = 3'h3;
    // Twice the factor per strap value, index 7 down to 0: 4,3,2,5,1,1.5,0.5,2.5
    localparam logic [7:0][3:0] CMS_FACTOR2 = {4'h8, 4'h6, 4'h4, 4'ha, 4'h2, 4'h3, 4'h1, 4'h5};

    //--------------------------------------------------------------------
    // Types
    //--------------------------------------------------------------------
    typedef enum logic [1:0] {
        CMS_MODE_PLL,
        CMS_MODE_DIRECT,
        CMS_MODE_PRESC
    } cms_mode_t;

    typedef struct packed {
        logic [2:0] strap;
        cms_mode_t  mode;
        logic       pll_en;
        logic       pll_free_run;
        logic       cpu_clk;
    } cms_status_t;

    localparam int CMS_STATUS_W = $bits(cms_status_t);

endpackage

module cms_clock_mode_select
    import cms_pkg::*;
#(
    parameter int PER_W = 16,
    parameter int HP_W  = 16
) (
    // Clock and reset
    input  wire logic                  i_core_clk,
    input  wire logic                  i_srst,
    // Pins
    input  wire logic                  i_osc_in,
    input  wire logic [2:0]            i_clock_mode_strap_pins,
    // Register port
    input  wire logic [CMS_ADDR_W-1:0] i_addr,
    input  wire logic [CMS_DATA_W-1:0] i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [CMS_DATA_W-1:0] o_rdata,
    // CPU clock
    output logic                       o_cpu_clk,
    output logic                       o_cpu_edge,
    output logic      [HP_W-1:0]       o_cpu_half_period_cnt,
    // Multiplier loop control
    output logic                       o_pll_enable,
    output logic                       o_pll_free_run,
    output logic      [3:0]            o_pll_factor2,
    output cms_mode_t                  o_mode
);

    //--------------------------------------------------------------------
    // Pin synchronisation
    //--------------------------------------------------------------------
    logic [3:0] pins_s;
    logic       osc_s;
    logic [2:0] strap_s;

    cms_sync #(
        .W (4)
    ) u_sync (
        .i_core_clk (i_core_clk),
        .i_async    ({i_osc_in, i_clock_mode_strap_pins}),
        .o_sync     (pins_s)
    );

    assign osc_s   = pins_s[3];
    assign strap_s = pins_s[2:0];

    //--------------------------------------------------------------------
    // Strap capture and mode decode
    //--------------------------------------------------------------------
    logic [2:0] strap_q;
    cms_mode_t  mode;
    logic [3:0] factor2;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            strap_q <= strap_s;
        end
    end

    assign mode    = (strap_q == CMS_STRAP_PRESC)  ? CMS_MODE_PRESC :
                     (strap_q == CMS_STRAP_DIRECT) ? CMS_MODE_DIRECT :
                                                     CMS_MODE_PLL;
    assign factor2 = CMS_FACTOR2[strap_q];

    //--------------------------------------------------------------------
    // Register port
    //--------------------------------------------------------------------
    logic                  owd_dis_q;
    logic [CMS_DATA_W-1:0] rdata_q;
    logic                  sel_cfg;
    logic                  sel_sts;
    cms_status_t           status;
    logic [CMS_DATA_W-1:0] rdata_d;

    assign sel_cfg = (i_addr == CMS_OFS_SYSCFG);
    assign sel_sts = (i_addr == CMS_OFS_STATUS);

    assign status.strap        = strap_q;
    assign status.mode         = mode;
    assign status.pll_en       = o_pll_enable;
    assign status.pll_free_run = o_pll_free_run;
    assign status.cpu_clk      = o_cpu_clk;

    assign rdata_d = !i_rd  ? '0 :
                     sel_cfg ? (CMS_DATA_W'(owd_dis_q) << CMS_OWD_DIS_BIT) :
                     sel_sts ? {{(CMS_DATA_W-CMS_STATUS_W){1'b0}}, status} :
                               '0;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            owd_dis_q <= CMS_OWD_DIS_RST;
            rdata_q   <= '0;
        end else begin
            rdata_q <= rdata_d;
            if (i_wr && sel_cfg) begin
                owd_dis_q <= i_wdata[CMS_OWD_DIS_BIT];
            end
        end
    end

    assign o_rdata = rdata_q;

    //--------------------------------------------------------------------
    // Multiplier loop control
    //--------------------------------------------------------------------
    assign o_pll_enable   = (mode == CMS_MODE_PLL) || !owd_dis_q;
    assign o_pll_free_run = (mode != CMS_MODE_PLL) && !owd_dis_q;
    assign o_pll_factor2  = factor2;
    assign o_mode         = mode;

    //--------------------------------------------------------------------
    // Input period measurement
    //--------------------------------------------------------------------
    logic             osc_prev_q;
    logic             osc_rise;
    logic [PER_W-1:0] cnt_q;
    logic [PER_W-1:0] period_q;

    assign osc_rise = osc_s && !osc_prev_q;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            // Track the pin in reset so release gives no false rise
            osc_prev_q <= osc_s;
            cnt_q      <= '0;
            period_q   <= '0;
        end else begin
            osc_prev_q <= osc_s;
            if (osc_rise) begin
                cnt_q    <= '0;
                period_q <= cnt_q + PER_W'(1);
            end else if (cnt_q != '1) begin
                cnt_q <= cnt_q + PER_W'(1);
            end
        end
    end

    //--------------------------------------------------------------------
    // Multiplier edge generator
    //--------------------------------------------------------------------
    // Twice the factor in edges per input period; the accumulator is
    // realigned on every input rise so the output stays locked.
    logic [PER_W-1:0] acc_q;
    logic [PER_W:0]   acc_sum;
    logic             pll_toggle;
    logic [PER_W-1:0] acc_d;

    assign acc_sum    = {1'b0, acc_q} + (PER_W+1)'(factor2);
    assign pll_toggle = (period_q != '0) && (acc_sum >= {1'b0, period_q});
    assign acc_d      = osc_rise   ? '0 :
                        pll_toggle ? PER_W'(acc_sum - {1'b0, period_q}) :
                                     acc_sum[PER_W-1:0];

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_d;
        end
    end

    //--------------------------------------------------------------------
    // CPU clock selection
    //--------------------------------------------------------------------
    logic             cpu_clk_q;
    logic             cpu_clk_d;
    logic             edge_q;
    logic [HP_W-1:0]  hp_cnt_q;

    assign cpu_clk_d = (mode == CMS_MODE_DIRECT) ? osc_s :
                       (mode == CMS_MODE_PRESC)  ? (cpu_clk_q ^ osc_rise) :
                                                   (cpu_clk_q ^ pll_toggle);

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            cpu_clk_q <= 1'b0;
            edge_q    <= 1'b0;
            hp_cnt_q  <= '0;
        end else begin
            cpu_clk_q <= cpu_clk_d;
            edge_q    <= cpu_clk_d ^ cpu_clk_q;
            if (cpu_clk_d ^ cpu_clk_q) begin
                hp_cnt_q <= hp_cnt_q + HP_W'(1);
            end
        end
    end

    assign o_cpu_clk             = cpu_clk_q;
    assign o_cpu_edge            = edge_q;
    assign o_cpu_half_period_cnt = hp_cnt_q;

    //--------------------------------------------------------------------
    // Phase length monitor
    //--------------------------------------------------------------------
    // Length of the phase ending at each edge pulse and of the one before;
    // checks wait for three pulses so no phase is cut short by reset.
    logic [PER_W-1:0] ph_cnt_q;
    logic [PER_W-1:0] ph_last_q;
    logic [1:0]       ph_seen_q;
    logic             ph_valid;

    assign ph_valid = (ph_seen_q == 2'h3) && o_cpu_edge;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            ph_cnt_q  <= '0;
            ph_last_q <= '0;
            ph_seen_q <= '0;
        end else if (o_cpu_edge) begin
            ph_cnt_q  <= PER_W'(1);
            ph_last_q <= ph_cnt_q;
            if (ph_seen_q != 2'h3) begin
                ph_seen_q <= ph_seen_q + 2'h1;
            end
        end else if (ph_cnt_q != '1) begin
            ph_cnt_q <= ph_cnt_q + PER_W'(1);
        end
    end

    //--------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------
    a_strap_capture: assert property (@(posedge i_core_clk) disable iff (i_srst)
        $fell(i_srst) |-> strap_q == $past(strap_s))
        else $error("strap not taken at reset release");

    a_strap_hold: assert property (@(posedge i_core_clk) disable iff (i_srst)
        !$past(i_srst) |-> $stable(strap_q))
        else $error("strap changed outside reset");

    a_factor_dflt: assert property (@(posedge i_core_clk) disable iff (i_srst)
        strap_q == CMS_STRAP_DFLT |-> o_pll_factor2 == 4'h8 && o_mode == CMS_MODE_PLL)
        else $error("default strap not factor four");

    a_presc_toggle: assert property (@(posedge i_core_clk) disable iff (i_srst)
        mode == CMS_MODE_PRESC && osc_rise |=> o_cpu_clk != $past(o_cpu_clk) && o_cpu_edge)
        else $error("prescaler missed input rise");

    a_presc_phase: assert property (@(posedge i_core_clk) disable iff (i_srst)
        mode == CMS_MODE_PRESC && !osc_rise |=> $stable(o_cpu_clk))
        else $error("prescaler phase ended early");

    a_direct_follow: assert property (@(posedge i_core_clk) disable iff (i_srst)
        mode == CMS_MODE_DIRECT |=> o_cpu_clk == $past(osc_s) && o_pll_free_run == !owd_dis_q)
        else $error("direct drive not following input");

    a_direct_rise: assert property (@(posedge i_core_clk) disable iff (i_srst)
        mode == CMS_MODE_DIRECT && osc_rise |=> o_cpu_clk ##1 o_cpu_edge == !o_cpu_clk)
        else $error("direct phase pairing broken");

    a_presc_len: assert property (@(posedge i_core_clk) disable iff (i_srst)
        mode == CMS_MODE_PRESC && ph_valid |-> ph_cnt_q == period_q)
        else $error("prescaler phase not one input period");

    a_direct_pair: assert property (@(posedge i_core_clk) disable iff (i_srst)
        mode == CMS_MODE_DIRECT && ph_valid && o_cpu_clk |-> ph_cnt_q + ph_last_q == period_q)
        else $error("direct phase pair not one input period");

    a_loop_free: assert property (@(posedge i_core_clk) disable iff (i_srst)
        mode != CMS_MODE_PLL && !owd_dis_q |-> o_pll_enable && o_pll_free_run)
        else $error("loop not free-running for watchdog");

    a_loop_off: assert property (@(posedge i_core_clk) disable iff (i_srst)
        mode != CMS_MODE_PLL && owd_dis_q |-> !o_pll_enable && !o_pll_free_run)
        else $error("loop not switched off");

    a_loop_used: assert property (@(posedge i_core_clk) disable iff (i_srst)
        mode == CMS_MODE_PLL && pll_toggle |=> o_cpu_edge && o_pll_enable && !o_pll_free_run)
        else $error("loop edge not driving cpu clock");

    a_edge_count: assert property (@(posedge i_core_clk) disable iff (i_srst)
        $changed(o_cpu_clk) |-> o_cpu_half_period_cnt == $past(o_cpu_half_period_cnt) + HP_W'(1))
        else $error("half-period count off");

    a_edge_both: assert property (@(posedge i_core_clk) disable iff (i_srst)
        !$past(i_srst) && $fell(o_cpu_clk) |-> o_cpu_edge)
        else $error("falling edge not flagged");

    c_presc: cover property (@(posedge i_core_clk) disable iff (i_srst)
        mode == CMS_MODE_PRESC && o_cpu_edge ##[1:20] o_cpu_edge);
    c_direct: cover property (@(posedge i_core_clk) disable iff (i_srst)
        mode == CMS_MODE_DIRECT && $rose(o_cpu_clk));
    c_pll: cover property (@(posedge i_core_clk) disable iff (i_srst)
        mode == CMS_MODE_PLL && pll_toggle ##[1:20] pll_toggle);
    c_owd_off: cover property (@(posedge i_core_clk) disable iff (i_srst)
        $rose(owd_dis_q) && mode != CMS_MODE_PLL);

endmodule // cms_clock_mode_select

`default_nettype wire

// [cms_osc_model.sv]
// Oscillator source model: free-running square wave with set high and low lengths.
// Assumes the bench core clock paces it; lengths are in core cycles, two or more.
`timescale 1ns/1ps
`default_nettype none

module cms_osc_model (
    // Clock
    input  wire logic       i_clk,
    // Wave shape
    input  wire logic [7:0] i_hi_cyc,
    input  wire logic [7:0] i_lo_cyc,
    // Oscillator pin
    output logic            o_osc
);
    logic [7:0] cnt_q = 8'h00;
    logic       osc_q = 1'b0;
    wire  [7:0] len   = osc_q ? i_hi_cyc : i_lo_cyc;

    // Free-running: a crystal does not stop between operations
    always @(posedge i_clk) begin
        if (cnt_q + 8'h01 >= len) begin
            cnt_q <= 8'h00;
            osc_q <= ~osc_q;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    assign o_osc = osc_q;
endmodule // cms_osc_model

`default_nettype wire

// [tb.sv]
// Self-checking bench for the CPU clock mode selector.
// Assumes the oscillator model drives the pin; 25 MHz core clock; checks sampled at falling edges.
`timescale 1ns/1ps
`default_nettype none

module tb;
    import cms_pkg::*;

    logic                  clk = 1'b0;
    logic                  srst = 1'b1;
    logic [2:0]            pins = 3'h7;
    logic [CMS_ADDR_W-1:0] addr = 8'h00;
    logic [CMS_DATA_W-1:0] wdata = 32'h0;
    logic                  wr = 1'b0;
    logic                  rd = 1'b0;
    logic [CMS_DATA_W-1:0] rdata;
    logic                  cpu_clk, cpu_edge, pll_en, pll_fr, osc;
    logic [15:0]           hp_cnt;
    logic [3:0]            f2;
    cms_mode_t             mode;
    int                    n_fail = 0;
    int                    checked = 0;
    int                    cyc = 0;

    cms_osc_model u_cms_osc_model (.i_clk(clk), .i_hi_cyc(8'h03), .i_lo_cyc(8'h05), .o_osc(osc));

    cms_clock_mode_select u_cms_clock_mode_select (
        .i_core_clk(clk), .i_srst(srst), .i_osc_in(osc), .i_clock_mode_strap_pins(pins),
        .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .o_cpu_clk(cpu_clk), .o_cpu_edge(cpu_edge), .o_cpu_half_period_cnt(hp_cnt),
        .o_pll_enable(pll_en), .o_pll_free_run(pll_fr), .o_pll_factor2(f2), .o_mode(mode));

    initial begin
        forever #20 clk = ~clk;
    end

    //------------------------------------------------------------
    // Shared tasks
    //------------------------------------------------------------
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic do_reset(input logic [2:0] s);
        @(posedge clk);
        srst <= 1'b1;
        pins <= s;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    // Cycles from one CPU clock edge pulse to the next
    task automatic next_edge(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (cpu_edge !== 1'b1 && n < 200);
    endtask

    //------------------------------------------------------------
    // Scenarios
    //------------------------------------------------------------
    task automatic t_decode();
        logic [3:0] f2_exp [8] = '{4'h5, 4'h1, 4'h3, 4'h2, 4'ha, 4'h4, 4'h6, 4'h8};
        cms_mode_t  m_exp;
        for (int p = 0; p < 8; p++) begin
            do_reset(p[2:0]);
            m_exp = (p == 1) ? CMS_MODE_PRESC : (p == 3) ? CMS_MODE_DIRECT : CMS_MODE_PLL;
            chk("mode", 32'(m_exp), 32'(mode));
            chk("factor2", 32'(f2_exp[p]), 32'(f2));
            chk("free_run", 32'(p == 1 || p == 3), 32'(pll_fr));
            chk("pll_en", 32'h1, 32'(pll_en));
        end
    endtask

    task automatic t_hold_and_regs();
        logic [31:0] d;
        do_reset(CMS_STRAP_PRESC);
        @(posedge clk);
        pins <= CMS_STRAP_DFLT;
        repeat (6) @(negedge clk);
        chk("mode_held", 32'(CMS_MODE_PRESC), 32'(mode));
        bus_rd(CMS_OFS_SYSCFG, d);
        chk("syscfg_rst", 32'h0, d);
        bus_rd(CMS_OFS_STATUS, d);
        chk("status", {25'h0, CMS_STRAP_PRESC, 2'(CMS_MODE_PRESC), 2'h3}, {25'h0, d[7:1]});
        bus_wr(CMS_OFS_SYSCFG, 32'h10);
        bus_rd(CMS_OFS_SYSCFG, d);
        chk("syscfg_wr", 32'h10, d);
        chk("pll_off", 32'h0, {30'h0, pll_en, pll_fr});
        bus_rd(8'h08, d);
        chk("unmapped", 32'h0, d);
        bus_wr(8'h08, 32'h0);
        bus_rd(CMS_OFS_SYSCFG, d);
        chk("unmapped_wr", 32'h10, d);
        bus_wr(CMS_OFS_SYSCFG, 32'h0);
        @(negedge clk);
        chk("pll_free", 32'h3, {30'h0, pll_en, pll_fr});
        do_reset(CMS_STRAP_DFLT);
        bus_wr(CMS_OFS_SYSCFG, 32'h10);
        @(negedge clk);
        chk("pll_mode_on", 32'h1, 32'(pll_en));
    endtask

    task automatic t_phase(input logic [2:0] s, input int hi, input int lo, input int pair);
        int         n, nh, nl;
        logic [15:0] c0;
        do_reset(s);
        n = 0;
        do begin
            next_edge(nh);
            n++;
        end while (!(cpu_edge === 1'b1 && cpu_clk === 1'b1) && n < 20);
        chk("rise_found", 32'h1, 32'(cpu_edge === 1'b1 && cpu_clk === 1'b1));
        c0 = hp_cnt;
        next_edge(nh);
        next_edge(nl);
        chk("high_phase", 32'(hi), 32'(nh));
        chk("low_phase", 32'(lo), 32'(nl));
        chk("two_phases", 32'(pair), 32'(nh + nl));
        chk("edge_count", 32'(c0 + 16'h2), 32'(hp_cnt));
    endtask

    // Locked loop gives twice the factor in edges per 8-cycle input period
    task automatic t_pll_runs(input logic [2:0] s, input int n_exp);
        logic [15:0] c0;
        do_reset(s);
        c0 = hp_cnt;
        repeat (60) @(negedge clk);
        chk("pll_toggles", 32'h1, 32'(hp_cnt !== c0));
        c0 = hp_cnt;
        repeat (16) @(negedge clk);
        chk("pll_edges", 32'(n_exp), 32'(hp_cnt - c0));
    endtask

    initial begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        t_decode();
        t_hold_and_regs();
        t_phase(CMS_STRAP_PRESC, 8, 8, 16);
        t_phase(CMS_STRAP_DIRECT, 3, 5, 8);
        t_pll_runs(CMS_STRAP_DFLT, 16);
        t_pll_runs(3'h5, 8);
        test_done();
    end
endmodule // tb

`default_nettype wire
